/* rtl/llo_config.sv */
// lane enable, sync-word, decimator gain and over-range register bank over avalon-mm
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module llo_config #(
   parameter int SAMPLE_W = 12
) (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_sys_rst,
   input  wire logic [llo_pkg::LLO_ADDR_W-1:0] i_avs_address,
   input  wire logic                       i_avs_read,
   input  wire logic                       i_avs_write,
   input  wire logic [31:0]                i_avs_writedata,
   input  wire logic [3:0]                 i_avs_byteenable,
   input  wire logic [7:0]                 i_mode_lanes,
   input  wire llo_pkg::llo_sample_t       i_sample,
   output logic [31:0]                     o_avs_readdata,
   output logic                            o_avs_waitrequest,
   output llo_pkg::llo_lane_ctrl_t         o_lane_ctrl,
   output llo_pkg::llo_sync_ctrl_t         o_sync_ctrl,
   output logic                            o_gain_decimator_gain_a,
   output llo_pkg::llo_ovr_t               o_ovr,
   output logic                            o_irq
);
   import llo_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]              extra_lane_q;
   logic [1:0]              sync_mode_q;
   logic                    gain_q;
   logic [7:0]              thr_i_q;
   logic [7:0]              thr_q_q;
   logic                    link_enable_q;
   logic                    power_down_q;
   logic [7:0]              link_mode_q;
   logic [3:0]              test_pat_q;
   logic                    enc_66_q;
   logic [LLO_IRQ_W-1:0]    irq_stat_q;
   logic [LLO_IRQ_W-1:0]    irq_mask_q;
   llo_bus_state_t          bus_state_q;

   logic [11:0]             reg_idx;
   logic                    wr_fire;
   logic                    rd_fire;
   logic [31:0]             rd_data_d;
   logic [31:0]             wdata_m;
   logic [LLO_IRQ_W-1:0]    ovr_event;

   // byte-enable aware write data, unselected lanes read zero
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wdata_m[b*8 +: 8] = i_avs_byteenable[b] ? i_avs_writedata[b*8 +: 8] : 8'h00;
      end
   end

   assign reg_idx = i_avs_address[LLO_ADDR_W-1:2];
   // ----------------------------------------------------------------
   // bus slave: one wait cycle then acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         bus_state_q <= LLO_BUS_IDLE;
      end else begin
         case (bus_state_q)
            LLO_BUS_IDLE: begin
               if (i_avs_read || i_avs_write) begin
                  bus_state_q <= LLO_BUS_ACK;
               end
            end
            LLO_BUS_ACK:  bus_state_q <= LLO_BUS_IDLE;
            default:      bus_state_q <= LLO_BUS_IDLE;
         endcase
      end
   end

   assign wr_fire = (bus_state_q == LLO_BUS_ACK) && i_avs_write;
   assign rd_fire = (bus_state_q == LLO_BUS_ACK) && i_avs_read;

   // waitrequest high except in the acknowledge cycle; registered
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= !((bus_state_q == LLO_BUS_IDLE) && (i_avs_read || i_avs_write));
      end
   end

   // ----------------------------------------------------------------
   // configuration writes; the bank does not block writes while the
   // link is enabled, software keeps that ordering
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         extra_lane_q  <= LLO_RST_EXTRA_LANE;
         sync_mode_q   <= LLO_RST_SYNC_WORD;
         gain_q        <= LLO_RST_GAIN;
         thr_i_q       <= LLO_RST_THR_I;
         thr_q_q       <= LLO_RST_THR_Q;
         link_enable_q <= 1'b0;
         power_down_q  <= 1'b0;
         link_mode_q   <= LLO_RST_LINK_MODE;
         test_pat_q    <= LLO_RST_TEST_PAT;
         enc_66_q      <= 1'b0;
         irq_mask_q    <= '0;
      end else if (wr_fire) begin
         case (reg_idx)
            LLO_IDX_EXTRA_LANE_B: extra_lane_q <= wdata_m[7:0];
            LLO_IDX_SYNC_WORD:    sync_mode_q  <= wdata_m[1:0];
            LLO_IDX_DEC_GAIN:     gain_q       <= wdata_m[0];
            LLO_IDX_OVR_THR_I:    thr_i_q      <= wdata_m[7:0];
            LLO_IDX_OVR_THR_Q:    thr_q_q      <= wdata_m[7:0];
            LLO_IDX_LINK_CTRL: begin
               link_enable_q <= wdata_m[LLO_CTRL_EN_BIT];
               power_down_q  <= wdata_m[LLO_CTRL_PD_BIT];
               link_mode_q   <= wdata_m[LLO_CTRL_MODE_LSB +: 8];
               test_pat_q    <= wdata_m[LLO_CTRL_TEST_LSB +: 4];
               enc_66_q      <= wdata_m[LLO_CTRL_ENC_BIT];
            end
            LLO_IDX_IRQ_MASK:     irq_mask_q   <= wdata_m[LLO_IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // lane control
   // ----------------------------------------------------------------
   logic [LLO_NUM_LANES-1:0] lane_req;
   logic [LLO_NUM_LANES-1:0] extra_only;
   logic [LLO_NUM_LANES-1:0] ser_chain;
   logic                     link_live;

   assign link_live = link_enable_q && !power_down_q;

   always_comb begin
      lane_req   = i_mode_lanes;
      extra_only = '0;
      ser_chain  = '0;
      for (int n = 1; n < LLO_NUM_LANES; n++) begin
         lane_req[n]   = i_mode_lanes[n] | extra_lane_q[n];
         extra_only[n] = extra_lane_q[n] & ~i_mode_lanes[n];
      end
      // serializer n clocks only when lanes 0..n are all requested
      ser_chain[0] = lane_req[0];
      for (int n = 1; n < LLO_NUM_LANES; n++) begin
         ser_chain[n] = ser_chain[n-1] & lane_req[n];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_lane_ctrl <= '0;
      end else begin
         o_lane_ctrl.link_mode    <= link_mode_q;
         o_lane_ctrl.test_pattern <= test_pat_q;
         o_lane_ctrl.clk_en       <= link_live ? lane_req : '0;
         for (int n = 0; n < LLO_NUM_LANES; n++) begin
            // extra lanes without the serializer bit only get link-layer clocks
            o_lane_ctrl.ser_clk[n] <= link_live && ser_chain[n] &&
                                      (!extra_only[n] || extra_lane_q[LLO_SER_BIT]);
            o_lane_ctrl.ramp[n]    <= extra_only[n] && ((test_pat_q == LLO_TEST_NONE) ||
                                      (test_pat_q == LLO_TEST_FIVE));
         end
      end
   end

   // ----------------------------------------------------------------
   // sync word and gain
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_sync_ctrl  <= '0;
         o_gain_decimator_gain_a <= 1'b0;
      end else begin
         o_sync_ctrl.command <= '0;
         if (!enc_66_q) begin
            o_sync_ctrl.content <= LLO_CONTENT_NONE;
         end else begin
            case (llo_sync_mode_t'(sync_mode_q))
               LLO_SW_CRC12: o_sync_ctrl.content <= LLO_CONTENT_CRC12;
               LLO_SW_FEC:   o_sync_ctrl.content <= LLO_CONTENT_FEC;
               default:      o_sync_ctrl.content <= LLO_CONTENT_NONE;
            endcase
         end
         o_gain_decimator_gain_a <= gain_q;
      end
   end

   // ----------------------------------------------------------------
   // over-range: threshold/256 of full scale, one result per sample
   // ----------------------------------------------------------------
   logic hit_i;
   logic hit_q;

   assign hit_i = i_sample.mag_i[SAMPLE_W-1 -: 8] >= thr_i_q;
   assign hit_q = i_sample.mag_q[SAMPLE_W-1 -: 8] >= thr_q_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_ovr <= '0;
      end else begin
         o_ovr.valid  <= i_sample.valid;
         o_ovr.ctrl_i <= i_sample.valid && hit_i;
         o_ovr.ctrl_q <= i_sample.valid && hit_q;
      end
   end

   // ----------------------------------------------------------------
   // interrupts: sticky, write one to clear, set wins over clear
   // ----------------------------------------------------------------
   assign ovr_event[LLO_IRQ_OVR_I] = i_sample.valid && hit_i;
   assign ovr_event[LLO_IRQ_OVR_Q] = i_sample.valid && hit_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         irq_stat_q <= '0;
      end else begin
         if (wr_fire && (reg_idx == LLO_IDX_IRQ_STATUS)) begin
            irq_stat_q <= (irq_stat_q & ~wdata_m[LLO_IRQ_W-1:0]) | ovr_event;
         end else begin
            irq_stat_q <= irq_stat_q | ovr_event;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      rd_data_d = LLO_RD_UNMAPPED;
      case (reg_idx)
         LLO_IDX_EXTRA_LANE_B: rd_data_d[7:0] = extra_lane_q;
         LLO_IDX_SYNC_WORD:    rd_data_d[1:0] = sync_mode_q;
         LLO_IDX_DEC_GAIN:     rd_data_d[0]   = gain_q;
         LLO_IDX_OVR_THR_I:    rd_data_d[7:0] = thr_i_q;
         LLO_IDX_OVR_THR_Q:    rd_data_d[7:0] = thr_q_q;
         LLO_IDX_LINK_CTRL: begin
            rd_data_d[LLO_CTRL_EN_BIT]        = link_enable_q;
            rd_data_d[LLO_CTRL_PD_BIT]        = power_down_q;
            rd_data_d[LLO_CTRL_MODE_LSB +: 8] = link_mode_q;
            rd_data_d[LLO_CTRL_TEST_LSB +: 4] = test_pat_q;
            rd_data_d[LLO_CTRL_ENC_BIT]       = enc_66_q;
         end
         LLO_IDX_IRQ_STATUS:   rd_data_d[LLO_IRQ_W-1:0] = irq_stat_q;
         LLO_IDX_IRQ_MASK:     rd_data_d[LLO_IRQ_W-1:0] = irq_mask_q;
         LLO_IDX_LANE_STATUS: begin
            rd_data_d[7:0]   = o_lane_ctrl.clk_en;
            rd_data_d[15:8]  = o_lane_ctrl.ser_clk;
            rd_data_d[23:16] = o_lane_ctrl.ramp;
         end
         default: rd_data_d = LLO_RD_UNMAPPED;
      endcase
   end

   // data registered in the wait cycle so it stands at the acknowledge edge
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_avs_readdata <= '0;
      end else if ((bus_state_q == LLO_BUS_IDLE) && i_avs_read) begin
         o_avs_readdata <= rd_data_d;
      end else if (rd_fire) begin
         o_avs_readdata <= o_avs_readdata;
      end
   end
endmodule

/* rtl/llo_pkg.sv */
// package: register map, field layout and carriers of the lane and over-range config block
package llo_pkg;
   // ----------------------------------------------------------------
   // register offsets (printed offsets are not word aligned: index*4)
   // ----------------------------------------------------------------
   localparam logic [11:0] LLO_IDX_EXTRA_LANE_B = 12'h20b;
   localparam logic [11:0] LLO_IDX_SYNC_WORD    = 12'h20f;
   localparam logic [11:0] LLO_IDX_DEC_GAIN     = 12'h210;
   localparam logic [11:0] LLO_IDX_OVR_THR_I    = 12'h211;
   localparam logic [11:0] LLO_IDX_OVR_THR_Q    = 12'h212;
   localparam logic [11:0] LLO_IDX_LINK_CTRL    = 12'h300;
   localparam logic [11:0] LLO_IDX_IRQ_STATUS   = 12'h301;
   localparam logic [11:0] LLO_IDX_IRQ_MASK     = 12'h302;
   localparam logic [11:0] LLO_IDX_LANE_STATUS  = 12'h303;
   localparam int          LLO_ADDR_W           = 14;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] LLO_RST_EXTRA_LANE = 8'h00;
   localparam logic [1:0] LLO_RST_SYNC_WORD  = 2'h0;
   localparam logic       LLO_RST_GAIN       = 1'b0;
   localparam logic [7:0] LLO_RST_THR_I      = 8'hf2;
   localparam logic [7:0] LLO_RST_THR_Q      = 8'hab;
   localparam logic [7:0] LLO_RST_LINK_MODE  = 8'h00;
   localparam logic [3:0] LLO_RST_TEST_PAT   = 4'h0;
   // ----------------------------------------------------------------
   // field positions and codes
   // ----------------------------------------------------------------
   localparam int          LLO_NUM_LANES     = 8;
   localparam int          LLO_SER_BIT       = 0;
   localparam int          LLO_CTRL_EN_BIT   = 0;
   localparam int          LLO_CTRL_PD_BIT   = 1;
   localparam int          LLO_CTRL_MODE_LSB = 8;
   localparam int          LLO_CTRL_TEST_LSB = 16;
   localparam int          LLO_CTRL_ENC_BIT  = 20;
   localparam logic [3:0]  LLO_TEST_NONE     = 4'h0;
   localparam logic [3:0]  LLO_TEST_RAMP     = 4'h4;
   localparam logic [3:0]  LLO_TEST_FIVE     = 4'h5;
   localparam int          LLO_IRQ_OVR_I     = 0;
   localparam int          LLO_IRQ_OVR_Q     = 1;
   localparam int          LLO_IRQ_W         = 2;
   localparam logic [31:0] LLO_RD_UNMAPPED   = 32'h0000_0000;

   typedef enum logic [1:0] {
      LLO_SW_CRC12 = 2'b00,
      LLO_SW_RSV1  = 2'b01,
      LLO_SW_FEC   = 2'b10,
      LLO_SW_RSV3  = 2'b11
   } llo_sync_mode_t;

   typedef enum logic [1:0] {
      LLO_CONTENT_NONE  = 2'b00,
      LLO_CONTENT_CRC12 = 2'b01,
      LLO_CONTENT_FEC   = 2'b10
   } llo_sync_content_t;

   typedef enum logic [1:0] {
      LLO_BUS_IDLE = 2'b00,
      LLO_BUS_ACK  = 2'b01
   } llo_bus_state_t;

   // per-lane controls, test pattern and link mode handed to the link layer
   typedef struct packed {
      logic [LLO_NUM_LANES-1:0] clk_en;
      logic [LLO_NUM_LANES-1:0] ser_clk;
      logic [LLO_NUM_LANES-1:0] ramp;
      logic [3:0]               test_pattern;
      logic [7:0]               link_mode;
   } llo_lane_ctrl_t;

   // sync-word content and command fields
   typedef struct packed {
      llo_sync_content_t content;
      logic [18:0]       command;
   } llo_sync_ctrl_t;

   // decimator sample carrying valid and magnitudes in; control bits go out in llo_ovr_t
   typedef struct packed {
      logic        valid;
      logic [11:0] mag_i;
      logic [11:0] mag_q;
   } llo_sample_t;

   typedef struct packed {
      logic valid;
      logic ctrl_i;
      logic ctrl_q;
   } llo_ovr_t;
endpackage

/* verif/llo_link_rx.sv */
// partner model: link receiver that consumes lane, sync-word and over-range controls
`timescale 1ns/10ps
module llo_link_rx
   import llo_pkg::*;
#(
   parameter logic [7:0] MODE_LANES = 8'h03
) (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_sys_rst,
   input  wire llo_pkg::llo_lane_ctrl_t i_lane_ctrl,
   input  wire llo_pkg::llo_sync_ctrl_t i_sync_ctrl,
   input  wire llo_pkg::llo_ovr_t       i_ovr,
   output logic [7:0]                  o_mode_lanes,
   output logic [7:0]                  o_ovr_seen_q,
   output logic                        o_cmd_bad_q
);
   // ------------------------------------------------------------
   // receiver side
   // ------------------------------------------------------------
   // lanes the chosen link mode needs, fixed for the whole run
   assign o_mode_lanes = MODE_LANES;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_ovr_seen_q <= 8'h00;
      end else if (i_ovr.valid && (i_ovr.ctrl_i || i_ovr.ctrl_q)) begin
         o_ovr_seen_q <= o_ovr_seen_q + 8'h01;
      end
   end
   // a receiver cannot decode command fields, so any nonzero one is sticky
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_cmd_bad_q <= 1'b0;
      end else if (i_sync_ctrl.command != 19'h0 || i_lane_ctrl.ser_clk[0] === 1'bx) begin
         o_cmd_bad_q <= 1'b1;
      end
   end
endmodule

/* verif/llo_config_sva.sv */
// checker: bus handshake, over-range timing and lane and sync output invariants
`timescale 1ns/10ps
module llo_config_sva
   import llo_pkg::*;
#(
   parameter int SAMPLE_W = 12
) (
   input wire logic                       i_ref_clk,
   input wire logic                       i_sys_rst,
   input wire logic [llo_pkg::LLO_ADDR_W-1:0] i_avs_address,
   input wire logic                       i_avs_read,
   input wire logic                       i_avs_write,
   input wire llo_pkg::llo_sample_t       i_sample,
   input wire logic                       o_avs_waitrequest,
   input wire llo_pkg::llo_lane_ctrl_t    o_lane_ctrl,
   input wire llo_pkg::llo_sync_ctrl_t    o_sync_ctrl,
   input wire llo_pkg::llo_ovr_t          o_ovr
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_req_idle;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_one_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   bus_one_wait_a: assert property (s_req_idle |=> s_one_ack)
      else $error("bus answer not exactly one wait cycle");
   bus_no_spur_a: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
      else $error("bus acknowledged without a request");
   ovr_valid_a: assert property (o_ovr.valid == $past(i_sample.valid))
      else $error("over-range valid not one cycle after sample");
   ovr_i_full_a: assert property (i_sample.valid && i_sample.mag_i[SAMPLE_W-1 -: 8] == 8'hff
      |=> o_ovr.ctrl_i) else $error("full scale i sample not flagged");
   ovr_q_full_a: assert property (i_sample.valid && i_sample.mag_q[SAMPLE_W-1 -: 8] == 8'hff
      |=> o_ovr.ctrl_q) else $error("full scale q sample not flagged");
   cmd_zero_a: assert property (o_sync_ctrl.command == 19'h0)
      else $error("sync command field not zero");
   content_ok_a: assert property (o_sync_ctrl.content != 2'b11)
      else $error("illegal sync content code");
   ser_in_clk_a: assert property ((o_lane_ctrl.ser_clk & ~o_lane_ctrl.clk_en) == 8'h00)
      else $error("serializer clocked on a disabled lane");
   ser_chain_a: assert property ((o_lane_ctrl.ser_clk & (o_lane_ctrl.ser_clk + 8'h01))
      == 8'h00) else $error("serializer clock with a lower lane missing");
endmodule
bind llo_config llo_config_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_sample(i_sample),
   .o_avs_waitrequest(o_avs_waitrequest), .o_lane_ctrl(o_lane_ctrl),
   .o_sync_ctrl(o_sync_ctrl), .o_ovr(o_ovr)
);

/* verif/llo_config_tb.sv */
// testbench: register access, lane control, sync word, gain and over-range checks
`timescale 1ns/10ps
module llo_config_tb;
   import llo_pkg::*;
   logic                  clk, rst, rd, wr, wreq, gain, irq, cmd_bad;
   logic [LLO_ADDR_W-1:0] addr;
   logic [31:0]           wdata, rdata, got;
   logic [7:0]            mode_lanes, ovr_seen;
   logic [23:0]           msk;
   llo_sample_t           smp;
   llo_lane_ctrl_t        lane;
   llo_sync_ctrl_t        sync;
   llo_ovr_t              ovr;
   int                    err_total = 0;
   int                    comparisons = 0;
   logic [7:0]  t_extra [6] = '{8'h0d, 8'h0c, 8'h29, 8'h0d, 8'h0d, 8'h0d};
   logic [23:0] t_ctrl  [6] = '{24'h000501, 24'h000501, 24'h050501, 24'h040501,
                                24'h000503, 24'h000500};
   logic [23:0] t_exp   [6] = '{24'h0c0f0f, 24'h0c030f, 24'h28032b, 24'h000f0f,
                                24'h000000, 24'h000000};
   llo_config u_dut (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .i_mode_lanes(mode_lanes), .i_sample(smp), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .o_lane_ctrl(lane), .o_sync_ctrl(sync),
      .o_gain_decimator_gain_a(gain), .o_ovr(ovr), .o_irq(irq));
   llo_link_rx u_rx (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_lane_ctrl(lane), .i_sync_ctrl(sync),
      .i_ovr(ovr), .o_mode_lanes(mode_lanes), .o_ovr_seen_q(ovr_seen),
      .o_cmd_bad_q(cmd_bad));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // request held until the edge that sees waitrequest low; data taken there
   task automatic bus(input logic is_wr, input logic [11:0] idx, input logic [31:0] d);
      int n;
      @(posedge clk);
      rd <= !is_wr;
      wr <= is_wr;
      addr <= {idx, 2'b00};
      wdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (wreq !== 1'b0) begin
         err_total++;
         results();
      end
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk(got, e);
   endtask
   task automatic sample(input logic [11:0] mi, input logic [11:0] mq,
                         input logic [1:0] e);
      @(posedge clk);
      smp <= '{1'b1, mi, mq};
      @(posedge clk);
      smp.valid <= 1'b0;
      #1;
      chk({29'h0, ovr}, {29'h0, 1'b1, e});
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = '0;
      wdata = 32'h0;
      smp = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdchk(LLO_IDX_EXTRA_LANE_B, 32'h0);
      rdchk(LLO_IDX_SYNC_WORD, 32'h0);
      rdchk(LLO_IDX_DEC_GAIN, 32'h0);
      rdchk(LLO_IDX_OVR_THR_I, 32'hf2);
      rdchk(LLO_IDX_OVR_THR_Q, 32'hab);
      bus(1'b1, 12'h100, 32'hffffffff);
      rdchk(12'h100, LLO_RD_UNMAPPED);
      // extra lanes are only touched with the link disabled
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, LLO_IDX_LINK_CTRL, 32'h0);
         bus(1'b1, LLO_IDX_EXTRA_LANE_B, {24'h0, t_extra[i]});
         bus(1'b1, LLO_IDX_LINK_CTRL, {8'h0, t_ctrl[i]});
         repeat (2) @(posedge clk);
         msk = (i < 4) ? 24'hffffff : 24'h00ffff;
         chk({8'h0, {lane.ramp, lane.ser_clk, lane.clk_en} & msk},
             {8'h0, t_exp[i] & msk});
         if (i < 4) begin
            chk({20'h0, lane.test_pattern, lane.link_mode}, {20'h0, t_ctrl[i][19:8]});
            rdchk(LLO_IDX_LANE_STATUS, {8'h0, t_exp[i]});
         end
      end
      for (int m = 0; m < 5; m++) begin
         bus(1'b1, LLO_IDX_LINK_CTRL, 32'h0);
         bus(1'b1, LLO_IDX_SYNC_WORD, m % 4);
         bus(1'b1, LLO_IDX_LINK_CTRL, (m < 4) ? 32'h100501 : 32'h000501);
         repeat (2) @(posedge clk);
         chk({30'h0, sync.content}, (m == 0) ? 32'h1 : (m == 2) ? 32'h2 : 32'h0);
         chk({13'h0, sync.command}, 32'h0);
         rdchk(LLO_IDX_SYNC_WORD, m % 4);
      end
      bus(1'b1, LLO_IDX_DEC_GAIN, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, gain}, 32'h1);
      rdchk(LLO_IDX_DEC_GAIN, 32'h1);
      bus(1'b1, LLO_IDX_DEC_GAIN, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, gain}, 32'h0);
      sample(12'hf20, 12'hab0, 2'b11);
      sample(12'hf1f, 12'haaf, 2'b00);
      bus(1'b1, LLO_IDX_OVR_THR_I, 32'h80);
      bus(1'b1, LLO_IDX_OVR_THR_Q, 32'h40);
      rdchk(LLO_IDX_OVR_THR_I, 32'h80);
      sample(12'h800, 12'h400, 2'b11);
      sample(12'h7ff, 12'h3ff, 2'b00);
      sample(12'h7ff, 12'h400, 2'b01);
      sample(12'h800, 12'h3ff, 2'b10);
      sample(12'hfff, 12'hff5, 2'b11);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(LLO_IDX_IRQ_STATUS, 32'h3);
      bus(1'b1, LLO_IDX_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, LLO_IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(LLO_IDX_IRQ_STATUS, 32'h2);
      bus(1'b1, LLO_IDX_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, LLO_IDX_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      chk({24'h0, ovr_seen}, 32'h5);
      chk({31'h0, cmd_bad}, 32'h0);
      results();
   end
endmodule
